// *** hw/aie_core.sv ***
// aie_core.sv: alu instruction execution unit with apb access
// assumes: single 100 MHz clock, apb master, fast memory controller
// takes the write-back pulse on the wb* ports
//
// Function
// - decode opcode, rd, rsa, rsb fields
// - rd and rsa reach 64, rsb 32
// - immediate form: rsa, rd, immediate operand
// - add/sub immediate zero-extends six bits
// - logic/compare/minmax immediate sign-extends ten bits
// - shift immediate uses six-bit style field
// - add overflow: same signs, result differs
// - sub overflow: signs differ, result matches b
// - only full-width add/sub touch overflow
// - no-overflow branch tests latest flag
// - modulo: low bits computed, upper from rsa
// - modulo widths one to fifteen, else 16
// - modulo operations leave overflow alone
// - zero tests only inside modulo field
// - memory update writes linked location
// - compares never request memory update
// - execute, test, redirect in one cycle
// - branch target is four past instruction
// - taken: slot then jump to target
// - not taken: slot then sequential flow
// - not taken, no always-execute: two stalls
// - always-execute not taken: run fetched pair
// - no condition means sequential flow
//
// The address map and the APB register port were left to the implementer.
`include "aie_consts.svh"
`default_nettype none
module aie_core
  import aie_pkg::*;
#(
  parameter int NREG = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wbValid,
  output logic [5:0] wbReg,
  output logic [15:0] wbData,
  output logic seqValid,
  output logic seqStall,
  output logic [15:0] seqAddr,
  output logic [15:0] resumeAddr
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic [15:0] regFile_q [NREG];
  logic [31:0] instr;
  logic [15:0] instAddr_q;
  logic [5:0] regSel_q;
  logic ovf_q;
  logic taken_q;
  logic reject_q;
  logic [15:0] result_q;
  aie_seq_t state_q;
  logic [15:0] plan_q [`AIE_PLAY_MAX];
  logic [`AIE_PLAY_MAX-1:0] planStall_q;
  logic [2:0] planLen_q;
  logic [2:0] playIdx_q;

  // a write to the instruction word while idle executes it at the access edge
  logic apbWr;
  logic apbRd;
  logic exec;
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign exec = apbWr && (paddr == `AIE_OFF_INSTR) && (state_q == AIE_IDLE);
  assign instr = pwdata;

  logic [5:0] opc;
  logic [5:0] rd;
  logic [5:0] rsa;
  logic [4:0] rsb;
  logic [2:0] abc;
  logic [3:0] modW;
  logic um;
  logic ae;
  assign opc = instr[`AIE_OPC_HI:`AIE_OPC_LO];
  assign rd = instr[`AIE_RD_HI:`AIE_RD_LO];
  assign rsa = instr[`AIE_RSA_HI:`AIE_RSA_LO];
  assign rsb = instr[`AIE_RSB_HI:`AIE_RSB_LO];
  assign abc = instr[`AIE_ABC_HI:`AIE_ABC_LO];
  assign um = instr[`AIE_UM_BIT];

  // immediate class by opcode
  function automatic logic isImm6(input logic [5:0] o);
    return o == `AIE_OP_ADD_WITH_IMMEDIATE || o == `AIE_OP_SUBTRACT_WITH_IMMEDIATE ||
           o == `AIE_OP_SFTLI || o == `AIE_OP_SFTRI;
  endfunction : isImm6

  function automatic logic isImm10(input logic [5:0] o);
    return o == `AIE_OP_BITWISE_AND_IMMEDIATE || o == `AIE_OP_ORI ||
           o == `AIE_OP_XORI || o == `AIE_OP_MAXI ||
           o == `AIE_OP_MINI || o == `AIE_OP_COMPARE_WITH_IMMEDIATE ||
           o == `AIE_OP_CMPPI;
  endfunction : isImm10

  function automatic logic isCmp(input logic [5:0] o);
    return o == `AIE_OP_CMP || o == `AIE_OP_COMPARE_WITH_IMMEDIATE ||
           o == `AIE_OP_COMPARE_PAIRED || o == `AIE_OP_CMPPI;
  endfunction : isCmp

  // ten-bit immediates overlay the modulo and always-execute fields
  assign modW = isImm10(opc) ? 4'h0 : instr[`AIE_MOD_HI:`AIE_MOD_LO];
  assign ae = (isImm10(opc) || isImm6(opc)) ? 1'b0 : instr[`AIE_AE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // operands and alu

  logic [15:0] opA;
  logic [15:0] opB;
  logic [15:0] aluRes;
  logic [15:0] merged;
  logic fieldZero;
  logic isAdd;
  logic isSub;
  logic ovfNew;
  logic ovfUse;
  logic cond;

  // second operand: register or immediate
  always_comb begin
    opA = regFile_q[rsa];
    if (isImm6(opc)) begin
      opB = {10'h000, instr[`AIE_IMM6_HI:0]};
    end else if (isImm10(opc)) begin
      opB = {{6{instr[`AIE_IMM10_HI]}}, instr[`AIE_IMM10_HI:0]};
    end else begin
      opB = regFile_q[{1'b0, rsb}];
    end
  end

  assign isAdd = (opc == `AIE_OP_ADD) || (opc == `AIE_OP_ADD_WITH_IMMEDIATE);
  assign isSub = (opc == `AIE_OP_SUB) || (opc == `AIE_OP_SUBTRACT_WITH_IMMEDIATE) || isCmp(opc);

  // operation select; shift amount from low four bits of operand b
  always_comb begin
    unique case (opc)
      `AIE_OP_ADD, `AIE_OP_ADD_WITH_IMMEDIATE: aluRes = opA + opB;
      `AIE_OP_AND, `AIE_OP_BITWISE_AND_IMMEDIATE: aluRes = opA & opB;
      `AIE_OP_OR, `AIE_OP_ORI: aluRes = opA | opB;
      `AIE_OP_XOR, `AIE_OP_XORI: aluRes = opA ^ opB;
      `AIE_OP_MAX, `AIE_OP_MAXI:
        aluRes = ($signed(opA) > $signed(opB)) ? opA : opB;
      `AIE_OP_MIN, `AIE_OP_MINI:
        aluRes = ($signed(opA) < $signed(opB)) ? opA : opB;
      `AIE_OP_SFTL, `AIE_OP_SFTLI: aluRes = opA << opB[3:0];
      `AIE_OP_SFTR, `AIE_OP_SFTRI: aluRes = opA >> opB[3:0];
      default: aluRes = opA - opB;
    endcase
  end

  aie_mod_merge #(
    .W(16)
  ) u_merge (
    .aluRes(aluRes),
    .rsaVal(opA),
    .width(modW),
    .merged(merged),
    .fieldZero(fieldZero)
  );

  // overflow only on full-width add and subtract, compares excluded
  always_comb begin
    ovfNew = ovf_q;
    if (modW == 4'h0 && !isCmp(opc)) begin
      if (isAdd) begin
        ovfNew = (opA[15] == opB[15]) && (aluRes[15] != opA[15]);
      end else if (isSub) begin
        ovfNew = (opA[15] != opB[15]) && (aluRes[15] == opB[15]);
      end
    end
  end
  assign ovfUse = ovfNew;

  ////////////////////////////////////////////////////////////////////////
  // branch condition

  logic minmaxCmp;
  logic aLtB;
  logic aEqB;
  assign minmaxCmp = isCmp(opc) || opc == `AIE_OP_MAX ||
                     opc == `AIE_OP_MAXI || opc == `AIE_OP_MIN ||
                     opc == `AIE_OP_MINI;
  assign aLtB = $signed(opA) < $signed(opB);
  assign aEqB = opA == opB;

  // compare family uses relations of rsa and operand b
  always_comb begin
    cond = 1'b0;
    if (minmaxCmp) begin
      unique case (abc)
        `AIE_ABC_Z: cond = aEqB;
        `AIE_ABC_NZ: cond = !aEqB;
        `AIE_ABC_LZ: cond = aLtB;
        `AIE_ABC_GEZ: cond = !aLtB;
        `AIE_ABC_LEZ: cond = aLtB || aEqB;
        `AIE_ABC_GT: cond = !aLtB && !aEqB;
        default: cond = 1'b0;
      endcase
    end else begin
      unique case (abc)
        `AIE_ABC_Z: cond = fieldZero;
        `AIE_ABC_NZ: cond = !fieldZero;
        `AIE_ABC_LZ: cond = merged[15];
        `AIE_ABC_GEZ: cond = !merged[15];
        `AIE_ABC_LEZ: cond = merged[15] || fieldZero;
        `AIE_ABC_NO: cond = !ovfUse;
        default: cond = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // playback plan of executed addresses

  logic [15:0] planAddr [`AIE_PLAY_MAX];
  logic [`AIE_PLAY_MAX-1:0] planStall;
  logic [2:0] planLen;
  logic [15:0] resumeNext;
  logic [15:0] n;
  assign n = instAddr_q;

  // slot first, then target, stall pair, or the fetched pair
  always_comb begin
    for (int i = 0; i < `AIE_PLAY_MAX; i++) begin
      planAddr[i] = n + 16'h0001;
    end
    planStall = '0;
    planLen = 3'h1;
    resumeNext = n + 16'h0002;
    if (abc != `AIE_ABC_NONE && cond) begin
      planAddr[1] = n + `AIE_BR_DIST;
      planLen = 3'h2;
      resumeNext = n + `AIE_BR_DIST + 16'h0001;
    end else if (abc != `AIE_ABC_NONE && ae) begin
      planAddr[1] = n + `AIE_BR_DIST;
      planAddr[2] = n + `AIE_BR_DIST + 16'h0001;
      planAddr[3] = n + 16'h0002;
      planAddr[4] = n + 16'h0003;
      planLen = 3'h5;
      resumeNext = n + `AIE_BR_DIST + 16'h0002;
    end else if (abc != `AIE_ABC_NONE) begin
      planStall[2:1] = 2'b11;
      planAddr[3] = n + 16'h0002;
      planAddr[4] = n + 16'h0003;
      planLen = 3'h5;
      resumeNext = n + `AIE_BR_DIST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state updates

  // register file: execute result, or software write through apb
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        regFile_q[i] <= `AIE_RST_WORD;
      end
    end else if (exec && !isCmp(opc)) begin
      regFile_q[rd] <= merged;
    end else if (apbWr && paddr == `AIE_OFF_RDATA) begin
      regFile_q[regSel_q] <= pwdata[15:0];
    end
  end

  // overflow flag and last branch outcome
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_q <= 1'b0;
      taken_q <= 1'b0;
      result_q <= `AIE_RST_WORD;
    end else if (exec) begin
      ovf_q <= ovfNew;
      taken_q <= (abc != `AIE_ABC_NONE) && cond;
      result_q <= merged;
    end
  end

  // software-set address and register index; rejected launches sticky
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instAddr_q <= `AIE_RST_WORD;
      regSel_q <= 6'h00;
      reject_q <= 1'b0;
    end else begin
      if (apbWr && paddr == `AIE_OFF_ADDR) begin
        instAddr_q <= pwdata[15:0];
      end
      if (apbWr && paddr == `AIE_OFF_RSEL) begin
        regSel_q <= pwdata[5:0];
      end
      if (apbWr && paddr == `AIE_OFF_INSTR && state_q != AIE_IDLE) begin
        reject_q <= 1'b1;
      end else if (apbWr && paddr == `AIE_OFF_STATUS &&
                   pwdata[`AIE_ST_REJ]) begin
        reject_q <= 1'b0;
      end
    end
  end

  // memory write-back pulse; compares never request it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbValid <= 1'b0;
      wbReg <= 6'h00;
      wbData <= `AIE_RST_WORD;
    end else begin
      wbValid <= exec && um && !isCmp(opc);
      if (exec) begin
        wbReg <= rd;
        wbData <= merged;
      end
    end
  end

  // sequencer: one executed address or stall per cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= AIE_IDLE;
      playIdx_q <= 3'h0;
      planLen_q <= 3'h0;
      planStall_q <= '0;
      resumeAddr <= `AIE_RST_WORD;
      for (int i = 0; i < `AIE_PLAY_MAX; i++) begin
        plan_q[i] <= `AIE_RST_WORD;
      end
    end else begin
      unique case (state_q)
        AIE_IDLE: begin
          if (exec) begin
            state_q <= AIE_PLAY;
            playIdx_q <= 3'h0;
            planLen_q <= planLen;
            planStall_q <= planStall;
            plan_q <= planAddr;
            resumeAddr <= resumeNext;
          end
        end
        AIE_PLAY: begin
          if (playIdx_q == planLen_q - 3'h1) begin
            state_q <= AIE_IDLE;
          end
          playIdx_q <= playIdx_q + 3'h1;
        end
      endcase
    end
  end

  // playback outputs registered for stable data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seqValid <= 1'b0;
      seqStall <= 1'b0;
      seqAddr <= `AIE_RST_WORD;
    end else begin
      seqValid <= (state_q == AIE_PLAY) && !planStall_q[playIdx_q];
      seqStall <= (state_q == AIE_PLAY) && planStall_q[playIdx_q];
      if (state_q == AIE_PLAY) begin
        seqAddr <= plan_q[playIdx_q];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped address

  logic mapped;
  assign mapped = paddr == `AIE_OFF_INSTR || paddr == `AIE_OFF_ADDR ||
                  paddr == `AIE_OFF_RSEL || paddr == `AIE_OFF_RDATA ||
                  paddr == `AIE_OFF_STATUS || paddr == `AIE_OFF_RESULT ||
                  paddr == `AIE_OFF_RESUME;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data captured at the access edge would lag; drive from state
  always_comb begin
    prdata = 32'h0000_0000;
    if (apbRd) begin
      unique case (paddr)
        `AIE_OFF_ADDR: prdata = {16'h0000, instAddr_q};
        `AIE_OFF_RSEL: prdata = {26'h0000000, regSel_q};
        `AIE_OFF_RDATA: prdata = {16'h0000, regFile_q[regSel_q]};
        `AIE_OFF_STATUS: begin
          prdata[`AIE_ST_OVF] = ovf_q;
          prdata[`AIE_ST_TAKEN] = taken_q;
          prdata[`AIE_ST_BUSY] = state_q == AIE_PLAY;
          prdata[`AIE_ST_REJ] = reject_q;
        end
        `AIE_OFF_RESULT: prdata = {16'h0000, result_q};
        `AIE_OFF_RESUME: prdata = {16'h0000, resumeAddr};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : aie_core
`default_nettype wire

// *** hw/aie_consts.svh ***
// aie_consts.svh: offsets, field positions, codes and reset values
// assumes: included by bare name from the alu core, the checker and the testbench
`ifndef AIE_CONSTS_SVH
`define AIE_CONSTS_SVH

// apb byte offsets, one aligned 32-bit word each
`define AIE_OFF_INSTR 8'h00
`define AIE_OFF_ADDR 8'h04
`define AIE_OFF_RSEL 8'h08
`define AIE_OFF_RDATA 8'h0C
`define AIE_OFF_STATUS 8'h10
`define AIE_OFF_RESULT 8'h14
`define AIE_OFF_RESUME 8'h18

// instruction word fields
`define AIE_OPC_HI 31
`define AIE_OPC_LO 26
`define AIE_RD_HI 25
`define AIE_RD_LO 20
`define AIE_UM_BIT 19
`define AIE_ABC_HI 18
`define AIE_ABC_LO 16
`define AIE_RSA_HI 15
`define AIE_RSA_LO 10
`define AIE_MOD_HI 9
`define AIE_MOD_LO 6
`define AIE_AE_BIT 5
`define AIE_RSB_HI 4
`define AIE_RSB_LO 0
`define AIE_IMM6_HI 5
`define AIE_IMM10_HI 9

// opcodes, triadic
`define AIE_OP_ADD 6'h20
`define AIE_OP_SUB 6'h21
`define AIE_OP_AND 6'h22
`define AIE_OP_OR 6'h23
`define AIE_OP_XOR 6'h24
`define AIE_OP_MAX 6'h25
`define AIE_OP_MIN 6'h26
`define AIE_OP_CMP 6'h27
`define AIE_OP_COMPARE_PAIRED 6'h28
`define AIE_OP_SFTL 6'h29
`define AIE_OP_SFTR 6'h2A
// opcodes, immediate
`define AIE_OP_ADD_WITH_IMMEDIATE 6'h30
`define AIE_OP_SUBTRACT_WITH_IMMEDIATE 6'h31
`define AIE_OP_BITWISE_AND_IMMEDIATE 6'h32
`define AIE_OP_ORI 6'h33
`define AIE_OP_XORI 6'h34
`define AIE_OP_MAXI 6'h35
`define AIE_OP_MINI 6'h36
`define AIE_OP_COMPARE_WITH_IMMEDIATE 6'h37
`define AIE_OP_CMPPI 6'h38
`define AIE_OP_SFTLI 6'h39
`define AIE_OP_SFTRI 6'h3A

// branch condition codes
`define AIE_ABC_NONE 3'h0
`define AIE_ABC_Z 3'h1
`define AIE_ABC_NZ 3'h2
`define AIE_ABC_LZ 3'h3
`define AIE_ABC_GEZ 3'h4
`define AIE_ABC_LEZ 3'h5
`define AIE_ABC_NO 3'h6
`define AIE_ABC_GT 3'h6

// status bits, reset value, branch distance and plan depth
`define AIE_ST_OVF 0
`define AIE_ST_TAKEN 1
`define AIE_ST_BUSY 2
`define AIE_ST_REJ 3
`define AIE_RST_WORD 16'h0000
`define AIE_BR_DIST 16'h0004
`define AIE_PLAY_MAX 5

`endif

// *** hw/aie_pkg.sv ***
// aie_pkg.sv: types of the alu execution block
// assumes: aie_consts.svh beside it
`default_nettype none
package aie_pkg;
  // sequencer playback states
  typedef enum logic [1:0] {
    AIE_IDLE = 2'b01,
    AIE_PLAY = 2'b10
  } aie_seq_t;
endpackage : aie_pkg
`default_nettype wire

// *** hw/aie_mod_merge.sv ***
// aie_mod_merge.sv: modulo width merge and in-field zero test
// assumes: width 0 means full 16-bit operation
`default_nettype none
module aie_mod_merge
  import aie_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic [W-1:0] aluRes,
  input wire logic [W-1:0] rsaVal,
  input wire logic [3:0] width,
  output logic [W-1:0] merged,
  output logic fieldZero
);
  logic [W-1:0] mask;

  // low bits from alu, upper bits copied from rsa
  always_comb begin
    if (width == 4'h0) begin
      mask = '1;
    end else begin
      mask = W'((W+1)'(1) << width) - W'(1);
    end
    merged = (aluRes & mask) | (rsaVal & ~mask);
    fieldZero = ((aluRes & mask) == '0);
  end
endmodule : aie_mod_merge
`default_nettype wire

// *** tb/aie_core_props.sv ***
// aie_core_props.sv: port checker for the alu execution core
// assumes: bound to aie_core, one clock, async active-low reset
`include "aie_consts.svh"
`default_nettype none
module aie_core_props
  import aie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic wbValid,
  input wire logic [5:0] wbReg,
  input wire logic seqValid,
  input wire logic seqStall,
  input wire logic [15:0] seqAddr,
  input wire logic [15:0] resumeAddr
);
  logic [15:0] addr_q;
  logic execNow;
  logic cmpNow;
  logic wantWb;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////
  // decode of any instruction write, busy or idle; the core executes it only while idle
  assign execNow = psel && penable && pwrite && paddr == `AIE_OFF_INSTR;
  assign cmpNow = pwdata[31:26] == `AIE_OP_CMP ||
    pwdata[31:26] == `AIE_OP_COMPARE_WITH_IMMEDIATE || pwdata[31:26] == `AIE_OP_COMPARE_PAIRED ||
    pwdata[31:26] == `AIE_OP_CMPPI;
  assign wantWb = pwdata[`AIE_UM_BIT] && !cmpNow;
  // shadow of the base address; targets are reckoned from it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 16'h0000;
    end else if (psel && penable && pwrite && paddr == `AIE_OFF_ADDR) begin
      addr_q <= pwdata[15:0];
    end
  end
  //////////////////////////////////////////////////////////////////////
  sequence slotS;
    seqValid && seqAddr == addr_q + 16'h0001;
  endsequence
  sequence tailS;
    (seqValid && seqAddr == addr_q + 16'h0002) ##1
    (seqValid && seqAddr == addr_q + 16'h0003);
  endsequence
  chk_wb_cause: assert property (
    wbValid |-> $past(execNow) && wbReg == $past(pwdata[25:20]))
    else $error("write-back without a matching execute");
  chk_wb_single: assert property (
    wbValid |=> !wbValid)
    else $error("write-back pulse longer than one cycle");
  chk_wb_request: assert property (
    execNow |=> wbValid == $past(wantWb))
    else $error("write-back request does not follow update option");
  chk_slot_first: assert property (
    execNow |-> ##2 slotS)
    else $error("committed slot not played two cycles after execute");
  chk_plain_flow: assert property (
    execNow && pwdata[18:16] == `AIE_ABC_NONE |-> ##3
      (!seqValid && !seqStall && resumeAddr == addr_q + 16'h0002))
    else $error("plain instruction did not continue sequentially");
  chk_jump_four: assert property (
    slotS ##1 seqValid |-> seqAddr == addr_q + 16'h0004)
    else $error("branch target is not four past the instruction");
  chk_stall_pair: assert property (
    seqValid ##1 seqStall |=> seqStall ##1 tailS)
    else $error("not-taken path lacks two stalls then fall-through");
  chk_ae_pair: assert property (
    seqValid && seqAddr == addr_q + 16'h0005 |=> tailS)
    else $error("always-execute path did not return to skipped pair");
endmodule : aie_core_props
bind aie_core aie_core_props u_props (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .wbValid(wbValid), .wbReg(wbReg),
  .seqValid(seqValid), .seqStall(seqStall), .seqAddr(seqAddr),
  .resumeAddr(resumeAddr));
`default_nettype wire

// *** tb/aie_far_model.sv ***
// aie_far_model.sv: fast-memory and sequencer stand-in for the core
// assumes: write-back pulses last one clock; stalls come as a two-clock pair
`default_nettype none
module aie_far_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wbValid,
  input wire logic [5:0] wbReg,
  input wire logic [15:0] wbData,
  input wire logic seqStall,
  output logic [7:0] wbCount,
  output logic [7:0] stallCount,
  output logic [5:0] lastReg,
  output logic [15:0] lastData
);
  //////////////////////////////////////////////////////////////////////
  // linked location takes the result; no separate store is needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbCount <= 8'h00;
      lastReg <= 6'h00;
      lastData <= 16'h0000;
    end else if (wbValid) begin
      wbCount <= wbCount + 8'h01;
      lastReg <= wbReg;
      lastData <= wbData;
    end
  end
  // discarded fetches, counted so the bench can price a not-taken branch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stallCount <= 8'h00;
    end else if (seqStall) begin
      stallCount <= stallCount + 8'h01;
    end
  end
endmodule : aie_far_model
`default_nettype wire

// *** tb/testbench.sv ***
// testbench.sv: table-driven self-checking bench for the alu core
// assumes: checker bound to the core, far model watching its outputs
`include "aie_consts.svh"
`default_nettype none
module testbench
  import aie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BASE = 16'h0100;
  // flags: overflow, write-back, taken
  typedef struct packed {
    logic [31:0] ins;
    logic [15:0] a, b, res;
    logic [2:0] fl;
    logic [15:0] rs;
  } aie_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, wbValid, seqValid, seqStall, er;
  logic [5:0] wbReg, lastReg;
  logic [15:0] wbData, seqAddr, resumeAddr, lastData;
  logic [7:0] wbCount, stallCount, w0, s0;
  int badCount = 0;
  int comparisons = 0;
  int cycles = 0;
  aie_row_t rows [21];
  //////////////////////////////////////////////////////////////////////
  aie_core dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wbValid(wbValid), .wbReg(wbReg),
    .wbData(wbData), .seqValid(seqValid), .seqStall(seqStall),
    .seqAddr(seqAddr), .resumeAddr(resumeAddr));
  aie_far_model far (.clk(clk), .rst_b(rst_b), .wbValid(wbValid),
    .wbReg(wbReg), .wbData(wbData), .seqStall(seqStall),
    .wbCount(wbCount), .stallCount(stallCount), .lastReg(lastReg),
    .lastData(lastData));
  //////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // hang guard: a run of 21 rows needs about five hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      badCount = badCount + 1;
      end_of_test();
    end
  end
  function automatic logic [31:0] mk(input logic [5:0] op,
      input logic um, input logic [2:0] c, input logic [9:0] lo);
    return {op, 6'h03, um, c, 6'h01, lo};
  endfunction : mk
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      badCount = badCount + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic setReg(input logic [5:0] idx, input logic [15:0] v);
    apb(1'b1, `AIE_OFF_RSEL, {26'h0, idx}, rdv, er);
    apb(1'b1, `AIE_OFF_RDATA, {16'h0, v}, rdv, er);
  endtask : setReg
  task automatic end_of_test();
    if (badCount == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{mk(`AIE_OP_ADD, 1'b1, 3'h0, 10'h002), 16'h7FFF, 16'h0001, 16'h8000, 3'b110, 16'h0102},
      '{mk(`AIE_OP_SUB, 1'b1, 3'h0, 10'h002), 16'h8000, 16'h0001, 16'h7FFF, 3'b110, 16'h0102},
      '{mk(`AIE_OP_AND, 1'b1, 3'h0, 10'h002), 16'hF0F0, 16'h0FF0, 16'h00F0, 3'b110, 16'h0102},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h0, 10'h102), 16'h1234, 16'h1111, 16'h1235, 3'b100, 16'h0102},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h0, 10'h002), 16'h1234, 16'h1111, 16'h2345, 3'b000, 16'h0102},
      '{mk(`AIE_OP_SUB, 1'b0, 3'h0, 10'h102), 16'h8000, 16'h0001, 16'h800F, 3'b000, 16'h0102},
      '{mk(`AIE_OP_ADD_WITH_IMMEDIATE, 1'b1, 3'h0, 10'h03F), 16'h0001, 16'h0000, 16'h0040, 3'b010, 16'h0102},
      '{mk(`AIE_OP_SUBTRACT_WITH_IMMEDIATE, 1'b0, 3'h0, 10'h03F), 16'h0000, 16'h0000, 16'hFFC1, 3'b000, 16'h0102},
      '{mk(`AIE_OP_BITWISE_AND_IMMEDIATE, 1'b0, 3'h0, 10'h3F0), 16'h1234, 16'h0000, 16'h1230, 3'b000, 16'h0102},
      '{mk(`AIE_OP_ORI, 1'b1, 3'h0, 10'h200), 16'h0000, 16'h0000, 16'hFE00, 3'b010, 16'h0102},
      '{mk(`AIE_OP_SFTLI, 1'b0, 3'h0, 10'h004), 16'h0001, 16'h0000, 16'h0010, 3'b000, 16'h0102},
      '{mk(`AIE_OP_CMP, 1'b1, 3'h1, 10'h002), 16'h0005, 16'h0005, 16'h0000, 3'b001, 16'h0105},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h1, 10'h002), 16'h0001, 16'hFFFF, 16'h0000, 3'b001, 16'h0105},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h2, 10'h002), 16'h0001, 16'hFFFF, 16'h0000, 3'b000, 16'h0104},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h2, 10'h022), 16'h0001, 16'hFFFF, 16'h0000, 3'b000, 16'h0106},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h1, 10'h102), 16'h1231, 16'h000F, 16'h1230, 3'b001, 16'h0105},
      '{mk(`AIE_OP_ADD, 1'b0, 3'h6, 10'h002), 16'h7FFF, 16'h0001, 16'h8000, 3'b100, 16'h0104},
      '{mk(`AIE_OP_AND, 1'b0, 3'h6, 10'h002), 16'hFFFF, 16'h0000, 16'h0000, 3'b100, 16'h0104},
      '{mk(`AIE_OP_SUB, 1'b0, 3'h3, 10'h002), 16'h0000, 16'h0001, 16'hFFFF, 3'b001, 16'h0105},
      '{mk(`AIE_OP_OR, 1'b0, 3'h4, 10'h002), 16'h0001, 16'h0000, 16'h0001, 3'b001, 16'h0105},
      '{mk(`AIE_OP_XOR, 1'b0, 3'h5, 10'h002), 16'h0001, 16'h0001, 16'h0000, 3'b001, 16'h0105}};
    // one row reaches the hardware half of the register set
    rows[2].ins[25:20] = 6'h3E;
    rows[2].ins[15:10] = 6'h21;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // cleared state, then an unmapped place
    apb(1'b0, `AIE_OFF_STATUS, 32'h0, rdv, er);
    check(rdv, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, rdv, er);
    check({rdv[31:1], er}, 32'h1);
    apb(1'b1, `AIE_OFF_ADDR, {16'h0, BASE}, rdv, er);
    foreach (rows[i]) begin
      w0 = wbCount;
      s0 = stallCount;
      setReg(rows[i].ins[15:10], rows[i].a);
      setReg(6'h02, rows[i].b);
      apb(1'b1, `AIE_OFF_INSTR, rows[i].ins, rdv, er);
      do apb(1'b0, `AIE_OFF_STATUS, 32'h0, rdv, er); while (rdv[2] !== 1'b0);
      // status keeps taken in bit 1 and overflow in bit 0
      check(rdv & 32'h3, {30'h0, rows[i].fl[0], rows[i].fl[2]});
      if (rows[i].ins[31:26] !== `AIE_OP_CMP) begin
        apb(1'b0, `AIE_OFF_RESULT, 32'h0, rdv, er);
        check(rdv, {16'h0, rows[i].res});
      end
      check({24'h0, wbCount - w0}, {31'h0, rows[i].fl[1]});
      if (rows[i].fl[1]) begin
        check({10'h0, lastReg, lastData}, {10'h0, rows[i].ins[25:20], rows[i].res});
      end
      check({16'h0, resumeAddr}, {16'h0, rows[i].rs});
      check({24'h0, stallCount - s0}, rows[i].rs == BASE + 16'h0004 ? 32'h2 : 32'h0);
    end
    // second reset after the last row clears the continuation point
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({16'h0, resumeAddr}, 32'h0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
